// file: rtl/vsqr_pkg.sv
// vsqr_pkg: constants and types for the sequencer register bank
// assumes a byte-wide i/o bus with 16-bit port addresses
package vsqr_pkg;
    // port addresses
    localparam logic [15:0] VSQR_SEQ_IDX_PORT  = 16'h03C4;
    localparam logic [15:0] VSQR_SEQ_DATA_PORT = 16'h03C5;
    localparam logic [15:0] VSQR_FCR_RD_PORT   = 16'h03CA;
    localparam logic [15:0] VSQR_COLOR_BASE    = 16'h03D0;
    localparam logic [15:0] VSQR_MONO_BASE     = 16'h03B0;
    localparam logic [15:0] VSQR_CRT_IDX_OFS   = 16'h0004;
    localparam logic [15:0] VSQR_CRT_DATA_OFS  = 16'h0005;
    localparam logic [15:0] VSQR_FCR_WR_OFS    = 16'h000A;
    // sequencer indices
    localparam logic [3:0] VSQR_IDX_RESET = 4'h0;
    localparam logic [3:0] VSQR_IDX_CLK   = 4'h1;
    localparam logic [3:0] VSQR_IDX_PWE   = 4'h2;
    localparam logic [3:0] VSQR_IDX_FMAP  = 4'h3;
    localparam logic [3:0] VSQR_IDX_MEM   = 4'h4;
    // writable-bit masks, reserved bits stay zero
    localparam logic [7:0] VSQR_MASK_RESET = 8'h03;
    localparam logic [7:0] VSQR_MASK_CLK   = 8'h3D;
    localparam logic [7:0] VSQR_MASK_PWE   = 8'h0F;
    localparam logic [7:0] VSQR_MASK_FMAP  = 8'h3F;
    localparam logic [7:0] VSQR_MASK_MEM   = 8'h0E;
    localparam logic [7:0] VSQR_MASK_FCR   = 8'h08;
    // field positions
    localparam int VSQR_FCR_VSC     = 3;
    localparam int VSQR_RST_SYNC    = 1;
    localparam int VSQR_RST_ASYNC   = 0;
    localparam int VSQR_CLK_OFF     = 5;
    localparam int VSQR_CLK_QUAD    = 4;
    localparam int VSQR_CLK_HALVE   = 3;
    localparam int VSQR_CLK_OTHER   = 2;
    localparam int VSQR_CLK_EIGHT   = 0;
    localparam int VSQR_MEM_CHAIN4  = 3;
    localparam int VSQR_MEM_SEQ     = 2;
    localparam int VSQR_MEM_EXT     = 1;
    // reset values
    localparam logic [7:0] VSQR_RST_VAL     = 8'h00;
    localparam logic [3:0] VSQR_SEQ_IDX_RST = 4'h0;
    localparam logic [4:0] VSQR_CRT_IDX_RST = 5'h00;
    // character clock: last dot count for 8 and 9 dot cells
    localparam logic [3:0] VSQR_LAST_DOT8 = 4'h7;
    localparam logic [3:0] VSQR_LAST_DOT9 = 4'h8;
    // host window limits in address bits (16k, 32k); extended memory skips the check
    localparam logic [17:0] VSQR_LIM_16K = 18'h04000;
    localparam logic [17:0] VSQR_LIM_32K = 18'h08000;

    typedef struct packed {
        logic [3:0]  seq_idx;
        logic [4:0]  crt_idx;
        logic [7:0]  seq_rst;
        logic [7:0]  seq_clk;
        logic [7:0]  seq_pwe;
        logic [7:0]  seq_fmap;
        logic [7:0]  seq_mem;
        logic [7:0]  feature_control;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        dot_div;
        logic [3:0]  dot_cnt;
        logic [1:0]  char_cnt;
    } vsqr_state_t;

    typedef struct packed {
        logic        wr;
        logic [17:0] addr;
    } vsqr_memreq_t;
endpackage

// file: rtl/vsqr_font_decode.sv
// vsqr_font_decode: turns a 3-bit font map code into its 8k region
// assumes the code is given as {high bit, two low bits} as stored
`timescale 1ns/10ps
module vsqr_font_decode
    import vsqr_pkg::*;
(
    input  wire logic [2:0] code_i,
    output logic      [2:0] region_o
);
    // high stored bit, code_i[2], is the least significant region bit
    assign region_o = {code_i[1], code_i[0], code_i[2]};
endmodule // vsqr_font_decode

// file: rtl/vsqr_regs.sv
// vsqr_regs: sequencer, feature-control and timing index registers
// assumes i/o strobes are one-cycle pulses synchronous to CLK_I
`timescale 1ns/10ps
module vsqr_regs
    import vsqr_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_B_I,
    // host i/o port
    input  wire logic [15:0] IO_ADDR_I,
    input  wire logic        IO_WR_I,
    input  wire logic        IO_RD_I,
    input  wire logic [7:0]  IO_WDATA_I,
    output logic      [7:0]  IO_RDATA_O,
    output logic             IO_RVALID_O,
    input  wire logic        MISC_COLOR_SEL_I,
    // timing controller data port strobes
    output logic      [4:0]  CRT_IDX_O,
    output logic             CRT_DATA_WR_O,
    output logic             CRT_DATA_RD_O,
    // display path
    input  wire logic        VSYNC_I,
    input  wire logic        VDE_I,
    input  wire logic        BLANK_I,
    output logic             VSYNC_O,
    output logic             BLANK_O,
    // sequencer timing
    output logic             DOT_EN_O,
    output logic             CHAR_EN_O,
    output logic             LOAD_EN_O,
    output logic             CHAR_WIDTH_EIGHT_O,
    output logic             SEQ_SYNC_CLR_O,
    output logic             SEQ_ASYNC_CLR_O,
    // font selection
    input  wire logic        FONT_SEL_I,
    output logic      [2:0]  FONT_A_REGION_O,
    output logic      [2:0]  FONT_B_REGION_O,
    output logic      [2:0]  FONT_REGION_O,
    // host memory writes
    input  vsqr_memreq_t     MEM_REQ_I,
    output logic      [3:0]  PLANE_WE_O,
    output logic             MEM_ADDR_OK_O
);
    // whole block state in one struct, registered in one place
    vsqr_state_t st_ff;
    vsqr_state_t nxt_st;

    // decode strobes and field views
    logic [15:0] base;
    logic        hit_seq_idx;
    logic        hit_seq_data;
    logic        hit_crt_idx;
    logic        hit_crt_data;
    logic        hit_fcr_wr;
    logic        hit_fcr_rd;
    logic        sync_halt_n;
    logic        async_halt_n;
    logic        screen_off;
    logic        serializer_quad_load;
    logic        dot_clock_halve;
    logic        load_every_other;
    logic        char_width_eight;
    logic        chain_four;
    logic        sequential_write_addr;
    logic        extended_memory_enable;
    logic        vert_sync_blend_sel;
    logic        cpu_addr_bit1;
    logic        cpu_addr_bit0;
    logic        dot_en;
    logic        char_en;
    logic        load_en;
    logic [3:0]  last_dot;
    logic [3:0]  plane_mask;
    logic [17:0] limit;
    logic [7:0]  seq_rd;

    // field views of the stored registers
    // bit positions come from the package, so the map lives in one file
    assign sync_halt_n            = st_ff.seq_rst[VSQR_RST_SYNC];
    assign async_halt_n           = st_ff.seq_rst[VSQR_RST_ASYNC];
    assign screen_off             = st_ff.seq_clk[VSQR_CLK_OFF];
    assign serializer_quad_load   = st_ff.seq_clk[VSQR_CLK_QUAD];
    assign dot_clock_halve        = st_ff.seq_clk[VSQR_CLK_HALVE];
    assign load_every_other       = st_ff.seq_clk[VSQR_CLK_OTHER];
    assign char_width_eight       = st_ff.seq_clk[VSQR_CLK_EIGHT];
    assign chain_four             = st_ff.seq_mem[VSQR_MEM_CHAIN4];
    assign sequential_write_addr  = st_ff.seq_mem[VSQR_MEM_SEQ];
    assign extended_memory_enable = st_ff.seq_mem[VSQR_MEM_EXT];
    assign vert_sync_blend_sel    = st_ff.feature_control[VSQR_FCR_VSC];
    assign cpu_addr_bit1          = MEM_REQ_I.addr[1];
    assign cpu_addr_bit0          = MEM_REQ_I.addr[0];

    // port decode; the relocatable group follows misc bit 0
    always_comb begin
        base         = MISC_COLOR_SEL_I ? VSQR_COLOR_BASE : VSQR_MONO_BASE;
        hit_seq_idx  = 1'b0;
        hit_seq_data = 1'b0;
        hit_crt_idx  = 1'b0;
        hit_crt_data = 1'b0;
        hit_fcr_wr   = 1'b0;
        hit_fcr_rd   = 1'b0;
        // fixed ports first, so a relocated port can never shadow them
        if (IO_ADDR_I == VSQR_SEQ_IDX_PORT) begin
            hit_seq_idx = 1'b1;
        end else if (IO_ADDR_I == VSQR_SEQ_DATA_PORT) begin
            hit_seq_data = 1'b1;
        end else if (IO_ADDR_I == VSQR_FCR_RD_PORT) begin
            hit_fcr_rd = 1'b1;
        end else if (IO_ADDR_I == base + VSQR_CRT_IDX_OFS) begin
            hit_crt_idx = 1'b1;
        end else if (IO_ADDR_I == base + VSQR_CRT_DATA_OFS) begin
            hit_crt_data = 1'b1;
        end else if (IO_ADDR_I == base + VSQR_FCR_WR_OFS) begin
            hit_fcr_wr = 1'b1;
        end
    end

    // sequencer data read mux; unused indices read zero
    // the index is not masked, so 5..F simply fall to the default
    always_comb begin
        seq_rd = 8'h00;
        case (st_ff.seq_idx)
            VSQR_IDX_RESET: seq_rd = st_ff.seq_rst;
            VSQR_IDX_CLK:   seq_rd = st_ff.seq_clk;
            VSQR_IDX_PWE:   seq_rd = st_ff.seq_pwe;
            VSQR_IDX_FMAP:  seq_rd = st_ff.seq_fmap;
            VSQR_IDX_MEM:   seq_rd = st_ff.seq_mem;
            default:        seq_rd = 8'h00;
        endcase
    end

    // dot, character and load enables derived from the core clock
    // a narrower cell set mid-cell catches up after one counter wrap
    always_comb begin
        last_dot = char_width_eight ? VSQR_LAST_DOT8 : VSQR_LAST_DOT9;
        dot_en   = dot_clock_halve ? st_ff.dot_div : 1'b1;
        char_en  = dot_en && (st_ff.dot_cnt == last_dot);
        if (serializer_quad_load) begin
            load_en = char_en && (st_ff.char_cnt == 2'h3);
        end else if (load_every_other) begin
            load_en = char_en && st_ff.char_cnt[0];
        end else begin
            load_en = char_en;
        end
    end

    // next state: register writes, read capture, counters
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.rvalid = 1'b0;
        nxt_st.rdata  = 8'h00;
        // index ports store the pointer, sequencer data and feature write ports the masked byte
        if (IO_WR_I) begin
            if (hit_seq_idx) begin
                nxt_st.seq_idx = IO_WDATA_I[3:0];
            end else if (hit_seq_data) begin
                case (st_ff.seq_idx)
                    VSQR_IDX_RESET: nxt_st.seq_rst  = IO_WDATA_I & VSQR_MASK_RESET;
                    VSQR_IDX_CLK:   nxt_st.seq_clk  = IO_WDATA_I & VSQR_MASK_CLK;
                    VSQR_IDX_PWE:   nxt_st.seq_pwe  = IO_WDATA_I & VSQR_MASK_PWE;
                    VSQR_IDX_FMAP:  nxt_st.seq_fmap = IO_WDATA_I & VSQR_MASK_FMAP;
                    VSQR_IDX_MEM:   nxt_st.seq_mem  = IO_WDATA_I & VSQR_MASK_MEM;
                    default:        nxt_st.seq_rst  = st_ff.seq_rst;
                endcase
            end else if (hit_crt_idx) begin
                nxt_st.crt_idx = IO_WDATA_I[4:0];
            end else if (hit_fcr_wr) begin
                nxt_st.feature_control = IO_WDATA_I & VSQR_MASK_FCR;
            end
        end
        // a read in the same cycle as a write still returns the old value
        // crt data reads are answered by the timing controller itself
        if (IO_RD_I) begin
            if (hit_seq_idx) begin
                nxt_st.rdata  = {4'h0, st_ff.seq_idx};
                nxt_st.rvalid = 1'b1;
            end else if (hit_seq_data) begin
                nxt_st.rdata  = seq_rd;
                nxt_st.rvalid = 1'b1;
            end else if (hit_crt_idx) begin
                nxt_st.rdata  = {3'h0, st_ff.crt_idx};
                nxt_st.rvalid = 1'b1;
            end else if (hit_fcr_rd) begin
                nxt_st.rdata  = st_ff.feature_control;
                nxt_st.rvalid = 1'b1;
            end
        end
        // timing counters; both halts clear them, and both also gate the enables below
        // halted counters restart at dot zero, so the first cell is full width
        if (!sync_halt_n || !async_halt_n) begin
            nxt_st.dot_div  = 1'b0;
            nxt_st.dot_cnt  = 4'h0;
            nxt_st.char_cnt = 2'h0;
        end else begin
            nxt_st.dot_div = ~st_ff.dot_div;
            if (char_en) begin
                nxt_st.dot_cnt  = 4'h0;
                nxt_st.char_cnt = st_ff.char_cnt + 2'h1;
            end else if (dot_en) begin
                nxt_st.dot_cnt = st_ff.dot_cnt + 4'h1;
            end
        end
    end

    // single state register
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            // all fields zero; the named ones are spelled out for clarity
            st_ff          <= '0;
            st_ff.seq_idx  <= VSQR_SEQ_IDX_RST;
            st_ff.crt_idx  <= VSQR_CRT_IDX_RST;
            st_ff.seq_rst  <= VSQR_RST_VAL;
            st_ff.seq_clk  <= VSQR_RST_VAL;
            st_ff.seq_pwe  <= VSQR_RST_VAL;
            st_ff.seq_fmap <= VSQR_RST_VAL;
            st_ff.seq_mem  <= VSQR_RST_VAL;
            st_ff.feature_control      <= VSQR_RST_VAL;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // host bus outputs; timing data strobes stay combinational so the
    // timing controller sees them in the host cycle itself
    assign IO_RDATA_O    = st_ff.rdata;
    assign IO_RVALID_O   = st_ff.rvalid;
    assign CRT_IDX_O     = st_ff.crt_idx;
    assign CRT_DATA_WR_O = IO_WR_I && hit_crt_data;
    assign CRT_DATA_RD_O = IO_RD_I && hit_crt_data;

    // display path: sync untouched by screen off, only blank forced
    // the monitor keeps its lock while the picture is dark
    assign VSYNC_O = vert_sync_blend_sel ? (VSYNC_I | VDE_I) : VSYNC_I;
    assign BLANK_O = BLANK_I | screen_off;

    // async halt gates the enables at once, without waiting for an edge
    // the counters themselves only clear on the next edge
    assign DOT_EN_O           = dot_en && async_halt_n && sync_halt_n;
    assign CHAR_EN_O          = char_en && async_halt_n && sync_halt_n;
    assign LOAD_EN_O          = load_en && async_halt_n && sync_halt_n;
    assign CHAR_WIDTH_EIGHT_O = char_width_eight;
    assign SEQ_SYNC_CLR_O     = ~sync_halt_n;
    assign SEQ_ASYNC_CLR_O    = ~async_halt_n;

    // font map decoders, one per map
    // the character attribute bit picks which map feeds the generator
    vsqr_font_decode u_font_a (
        .code_i   ({st_ff.seq_fmap[5], st_ff.seq_fmap[3], st_ff.seq_fmap[2]}),
        .region_o (FONT_A_REGION_O)
    );
    vsqr_font_decode u_font_b (
        .code_i   ({st_ff.seq_fmap[4], st_ff.seq_fmap[1], st_ff.seq_fmap[0]}),
        .region_o (FONT_B_REGION_O)
    );
    assign FONT_REGION_O = FONT_SEL_I ? FONT_B_REGION_O : FONT_A_REGION_O;

    // host write plane steering; chain four wins over the sequential bit
    // limitation: only writes are steered here, reads take another path
    always_comb begin
        if (chain_four) begin
            plane_mask = 4'h1 << {cpu_addr_bit1, cpu_addr_bit0};
        end else if (sequential_write_addr) begin
            plane_mask = 4'hF;
        end else if (cpu_addr_bit0) begin
            plane_mask = 4'hA;
        end else begin
            plane_mask = 4'h5;
        end
    end
    assign PLANE_WE_O = MEM_REQ_I.wr ? (plane_mask & st_ff.seq_pwe[3:0]) : 4'h0;

    // window limit: 32k while odd/even halves the plane, else 16k
    // trade-off: the 16k/32k split is fixed, not a register
    always_comb begin
        if (!chain_four && !sequential_write_addr) begin
            limit = VSQR_LIM_32K;
        end else begin
            limit = VSQR_LIM_16K;
        end
    end
    assign MEM_ADDR_OK_O = extended_memory_enable || (MEM_REQ_I.addr < limit);
endmodule // vsqr_regs

// file: test/vsqr_regs_asserts.sv
// vsqr_regs_chk: port-level checks of the sequencer register bank
// assumes one clock domain and async active-low reset, bound to vsqr_regs
`timescale 1ns/10ps
module vsqr_regs_chk
    import vsqr_pkg::*;
(
    input  wire logic         CLK_I,
    input  wire logic         RST_B_I,
    input  wire logic  [15:0] IO_ADDR_I,
    input  wire logic         IO_WR_I,
    input  wire logic         IO_RD_I,
    input  wire logic  [7:0]  IO_WDATA_I,
    input  wire logic  [7:0]  IO_RDATA_O,
    input  wire logic         IO_RVALID_O,
    input  wire logic         MISC_COLOR_SEL_I,
    input  wire logic  [4:0]  CRT_IDX_O,
    input  wire logic         CRT_DATA_WR_O,
    input  wire logic         CRT_DATA_RD_O,
    input  wire logic         VSYNC_I,
    input  wire logic         VDE_I,
    input  wire logic         BLANK_I,
    input  wire logic         VSYNC_O,
    input  wire logic         BLANK_O,
    input  wire logic         CHAR_EN_O,
    input  wire logic         LOAD_EN_O,
    input  wire logic         SEQ_ASYNC_CLR_O,
    input  wire logic         FONT_SEL_I,
    input  wire logic  [2:0]  FONT_A_REGION_O,
    input  wire logic  [2:0]  FONT_B_REGION_O,
    input  wire logic  [2:0]  FONT_REGION_O,
    input  wire vsqr_memreq_t MEM_REQ_I,
    input  wire logic  [3:0]  PLANE_WE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    logic [15:0] base;
    // relocatable port base follows the misc select bit
    assign base = MISC_COLOR_SEL_I ? VSQR_COLOR_BASE : VSQR_MONO_BASE;

    property p_vsync; VSYNC_I |-> VSYNC_O; endproperty
    a_vsync: assert property (p_vsync) else $error("vsync lost");
    property p_vsync_low; !VSYNC_I && !VDE_I |-> !VSYNC_O; endproperty
    a_vsync_low: assert property (p_vsync_low) else $error("vsync without source");
    property p_blank; BLANK_I |-> BLANK_O; endproperty
    a_blank: assert property (p_blank) else $error("blank lost");
    property p_idx_rd; IO_RD_I && IO_ADDR_I == VSQR_SEQ_IDX_PORT |=> IO_RVALID_O && IO_RDATA_O[7:4] == 4'h0; endproperty
    a_idx_rd: assert property (p_idx_rd) else $error("index read bad");
    property p_fcr_rd; IO_RD_I && IO_ADDR_I == VSQR_FCR_RD_PORT |=> IO_RVALID_O && (IO_RDATA_O & ~VSQR_MASK_FCR) == 8'h00; endproperty
    a_fcr_rd: assert property (p_fcr_rd) else $error("feature read bad");
    property p_fcr_nord; IO_RD_I && IO_ADDR_I == base + VSQR_FCR_WR_OFS |=> !IO_RVALID_O; endproperty
    a_fcr_nord: assert property (p_fcr_nord) else $error("write port answered");
    property p_crt_wr; CRT_DATA_WR_O == (IO_WR_I && IO_ADDR_I == base + VSQR_CRT_DATA_OFS); endproperty
    a_crt_wr: assert property (p_crt_wr) else $error("timing data strobe bad");
    property p_crt_rd; CRT_DATA_RD_O == (IO_RD_I && IO_ADDR_I == base + VSQR_CRT_DATA_OFS); endproperty
    a_crt_rd: assert property (p_crt_rd) else $error("timing data read strobe bad");
    property p_crt_rd_nv; IO_RD_I && IO_ADDR_I == base + VSQR_CRT_DATA_OFS |=> !IO_RVALID_O; endproperty
    a_crt_rd_nv: assert property (p_crt_rd_nv) else $error("timing data read answered here");
    property p_crt_idx; IO_WR_I && IO_ADDR_I == base + VSQR_CRT_IDX_OFS |=> CRT_IDX_O == $past(IO_WDATA_I[4:0]); endproperty
    a_crt_idx: assert property (p_crt_idx) else $error("timing index bad");
    property p_load; LOAD_EN_O |-> CHAR_EN_O; endproperty
    a_load: assert property (p_load) else $error("load off char clock");
    property p_async; SEQ_ASYNC_CLR_O |-> !LOAD_EN_O && !CHAR_EN_O; endproperty
    a_async: assert property (p_async) else $error("halted but running");
    property p_font; FONT_REGION_O == (FONT_SEL_I ? FONT_B_REGION_O : FONT_A_REGION_O); endproperty
    a_font: assert property (p_font) else $error("font select bad");
    property p_we; !MEM_REQ_I.wr |-> PLANE_WE_O == 4'h0; endproperty
    a_we: assert property (p_we) else $error("plane enable without write");
endmodule // vsqr_regs_chk

bind vsqr_regs vsqr_regs_chk u_chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .IO_ADDR_I(IO_ADDR_I), .IO_WR_I(IO_WR_I),
    .IO_RD_I(IO_RD_I), .IO_WDATA_I(IO_WDATA_I), .IO_RDATA_O(IO_RDATA_O), .IO_RVALID_O(IO_RVALID_O),
    .MISC_COLOR_SEL_I(MISC_COLOR_SEL_I), .CRT_IDX_O(CRT_IDX_O), .CRT_DATA_WR_O(CRT_DATA_WR_O),
    .VSYNC_I(VSYNC_I), .VDE_I(VDE_I), .BLANK_I(BLANK_I), .VSYNC_O(VSYNC_O), .BLANK_O(BLANK_O),
    .CHAR_EN_O(CHAR_EN_O), .CRT_DATA_RD_O(CRT_DATA_RD_O),
    .LOAD_EN_O(LOAD_EN_O), .SEQ_ASYNC_CLR_O(SEQ_ASYNC_CLR_O), .FONT_SEL_I(FONT_SEL_I),
    .FONT_A_REGION_O(FONT_A_REGION_O), .FONT_B_REGION_O(FONT_B_REGION_O), .FONT_REGION_O(FONT_REGION_O),
    .MEM_REQ_I(MEM_REQ_I), .PLANE_WE_O(PLANE_WE_O));

// file: test/vsqr_host.sv
// vsqr_host: host cpu model issuing byte i/o cycles
// assumes strobes are taken on the rising clock edge
`timescale 1ns/10ps
module vsqr_host (
    input  wire logic        clk_i,
    output logic      [15:0] addr_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic      [7:0]  wdata_o
);
    // idle bus at time zero
    initial begin
        addr_o = 16'h0000;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // one strobe cycle, then the bus shows inverted values, not stale ones
    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wdata_o = d;
        wr_o = w;
        rd_o = !w;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
endmodule // vsqr_host

// file: test/vsqr_regs_tb_top.sv
// vsqr_regs_tb_top: self-checking bench for the sequencer register bank
// assumes the host model drives the i/o port, bench drives display and memory inputs
`timescale 1ns/10ps
module vsqr_regs_tb_top;
    import vsqr_pkg::*;
    logic clk, rst_b, wr, rd, csel, vs, vde, blk, fsel, rvalid, vso, blo, chr, ld, sclr, aclr, aok, c8, dot;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, v, lfsr = 8'h19;
    logic [2:0] fa, fb, fr, q;
    logic [4:0] cidx;
    logic [3:0] pwe;
    vsqr_memreq_t mreq;
    logic [7:0] exp_q[$];
    logic [7:0] msk[5] = '{VSQR_MASK_RESET, VSQR_MASK_CLK, VSQR_MASK_PWE, VSQR_MASK_FMAP, VSQR_MASK_MEM};
    logic [35:0] mtab[9] = '{36'hF80000241, 36'hF00000DA1, 36'hF00000051, 36'hF400000F1, 36'hFC0000381,
                            36'h540000051, 36'hF404000F0, 36'hF007FFFA1, 36'hF23FFFFA1};
    logic [15:0] ctab[6] = '{16'h0010, 16'h0112, 16'h0808, 16'h0509, 16'h1004, 16'h1404};
    int num_errors = 0, samples_checked = 0;

    vsqr_host u_host (.clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
    vsqr_regs u_dut (.CLK_I(clk), .RST_B_I(rst_b), .IO_ADDR_I(addr), .IO_WR_I(wr), .IO_RD_I(rd),
        .IO_WDATA_I(wdata), .IO_RDATA_O(rdata), .IO_RVALID_O(rvalid), .MISC_COLOR_SEL_I(csel),
        .CRT_IDX_O(cidx), .CRT_DATA_WR_O(), .CRT_DATA_RD_O(), .VSYNC_I(vs), .VDE_I(vde), .BLANK_I(blk),
        .VSYNC_O(vso), .BLANK_O(blo), .DOT_EN_O(dot), .CHAR_EN_O(chr), .LOAD_EN_O(ld), .CHAR_WIDTH_EIGHT_O(c8),
        .SEQ_SYNC_CLR_O(sclr), .SEQ_ASYNC_CLR_O(aclr), .FONT_SEL_I(fsel), .FONT_A_REGION_O(fa),
        .FONT_B_REGION_O(fb), .FONT_REGION_O(fr), .MEM_REQ_I(mreq), .PLANE_WE_O(pwe), .MEM_ADDR_OK_O(aok));

    // 25 mhz core clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function automatic logic [7:0] nxt();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd_exp(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.io(1'b0, a, 8'h00);
    endtask
    // index first, then data, so the data port hits the chosen register
    task automatic swr(input logic [3:0] i, input logic [7:0] d);
        u_host.io(1'b1, VSQR_SEQ_IDX_PORT, {4'h0, i});
        u_host.io(1'b1, VSQR_SEQ_DATA_PORT, d);
    endtask
    // counts load pulses over a whole number of periods, so phase does not matter
    task automatic cnt(input logic [7:0] e, input logic [7:0] ed);
        int n;
        int nd;
        n = 0;
        nd = 0;
        repeat (40) @(negedge clk);
        repeat (144) begin
            @(negedge clk);
            if (ld === 1'b1) n++;
            if (dot === 1'b1) nd++;
        end
        chk(8'(n), e);
        chk(8'(nd), ed);
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // read answers are matched in order against the oldest note, mid-cycle
    always @(negedge clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) chk(rdata, 8'hXX);
            else chk(rdata, exp_q.pop_front());
        end
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize();
    end
    initial begin
        {rst_b, csel, vs, vde, blk, fsel} = 6'b010000;
        mreq = '0;
        repeat (16) @(posedge clk);
        #1 rst_b = 1'b1;
        rd_exp(VSQR_FCR_RD_PORT, 8'h00);
        rd_exp(16'h03D4, 8'h00);
        for (int i = 0; i < 5; i++) begin
            swr(4'(i), nxt());
            rd_exp(VSQR_SEQ_DATA_PORT, lfsr & msk[i]);
        end
        swr(4'h7, 8'hFF);
        rd_exp(VSQR_SEQ_DATA_PORT, 8'h00);
        u_host.io(1'b0, 16'h0300, 8'h00);
        $display("test seq regs done");
        u_host.io(1'b1, 16'h03DA, 8'hFF);
        rd_exp(VSQR_FCR_RD_PORT, 8'h08);
        u_host.io(1'b0, 16'h03DA, 8'h00);
        vde = 1'b1;
        #1 chk({7'h0, vso}, 8'h01);
        csel = 1'b0;
        u_host.io(1'b1, 16'h03DA, 8'h00);
        rd_exp(VSQR_FCR_RD_PORT, 8'h08);
        u_host.io(1'b1, 16'h03BA, 8'h00);
        rd_exp(VSQR_FCR_RD_PORT, 8'h00);
        chk({7'h0, vso}, 8'h00);
        u_host.io(1'b1, 16'h03B4, 8'hFF);
        rd_exp(16'h03B4, 8'h1F);
        chk({3'h0, cidx}, 8'h1F);
        u_host.io(1'b1, 16'h03B5, 8'h00);
        u_host.io(1'b0, 16'h03B5, 8'h00);
        $display("test feature and timing index done");
        foreach (mtab[i]) begin
            swr(4'h2, {4'h0, mtab[i][35:32]});
            swr(4'h4, {4'h0, mtab[i][31:28]});
            mreq.addr = mtab[i][25:8];
            mreq.wr = 1'b1;
            #1 chk({4'h0, pwe}, {4'h0, mtab[i][7:4]});
            chk({7'h0, aok}, {7'h0, mtab[i][0]});
            mreq.wr = 1'b0;
        end
        $display("test memory done");
        for (int r = 0; r < 8; r++) begin
            q = 3'(7 - r);
            v = {2'b00, 1'(r), q[0], 1'(r >> 2), 1'(r >> 1), q[2], q[1]};
            swr(4'h3, v);
            fsel = 1'(r);
            #1 chk({5'h0, fa}, 8'(r));
            chk({5'h0, fb}, {5'h0, q});
            chk({5'h0, fr}, fsel ? {5'h0, q} : 8'(r));
        end
        $display("test font done");
        swr(4'h0, 8'h03);
        foreach (ctab[i]) begin
            swr(4'h1, ctab[i][15:8]);
            chk({7'h0, c8}, {7'h0, ctab[i][8]});
            cnt(ctab[i][7:0], ctab[i][11] ? 8'h48 : 8'h90);
        end
        swr(4'h0, 8'h01);
        chk({7'h0, sclr}, 8'h01);
        cnt(8'h00, 8'h00);
        swr(4'h0, 8'h02);
        chk({7'h0, aclr}, 8'h01);
        cnt(8'h00, 8'h00);
        swr(4'h1, 8'h20);
        {vs, vde, blk} = 3'b100;
        #1 chk({6'h0, blo, vso}, 8'h03);
        $display("test timing done");
        repeat (4) @(posedge clk);
        chk(8'(exp_q.size()), 8'h00);
        summarize();
    end
endmodule // vsqr_regs_tb_top
